/* rtl/rac_axil.sv */
// AXI4-Lite register slave for the RTC alarm control block
`include "rac_defs.svh"
module rac_axil import rac_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] awaddr_in,
	input wire logic awvalid_in,
	output logic awready_out,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] wstrb_in,
	input wire logic wvalid_in,
	output logic wready_out,
	output logic [1:0] bresp_out,
	output logic bvalid_out,
	input wire logic bready_in,
	input wire logic [7:0] araddr_in,
	input wire logic arvalid_in,
	output logic arready_out,
	output logic [31:0] rdata_out,
	output logic [1:0] rresp_out,
	output logic rvalid_out,
	input wire logic rready_in,
	output logic wr_en_out,
	output logic [7:0] wr_addr_out,
	output logic [31:0] wr_data_out,
	output logic [3:0] wr_strb_out,
	output logic [7:0] rd_addr_out,
	input wire logic [31:0] rd_data_in
);
	rac_axil_s s;
	rac_axil_s n;

	always_comb begin
		n = s;
		n.wr_en = 1'b0;
		n.rd_en = 1'b0;
		if (awvalid_in && s.awready) begin
			n.aw_held = 1'b1;
			n.waddr = awaddr_in;
		end
		if (wvalid_in && s.wready) begin
			n.w_held = 1'b1;
			n.wdata = wdata_in;
			n.wstrb = wstrb_in;
		end
		if (s.bvalid && bready_in) begin
			n.bvalid = 1'b0;
		end
		if (s.aw_held && s.w_held && !s.bvalid) begin
			n.wr_en = 1'b1;
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
		end
		n.awready = !n.aw_held && !n.bvalid;
		n.wready = !n.w_held && !n.bvalid;
		if (arvalid_in && s.arready) begin
			n.arready = 1'b0;
			n.rd_en = 1'b1;
			n.raddr = araddr_in;
		end
		// Data fixed two edges after the address: far inside the read limit
		if (s.rd_en) begin
			n.rvalid = 1'b1;
			n.rdata = rd_data_in;
		end
		if (s.rvalid && rready_in) begin
			n.rvalid = 1'b0;
			n.arready = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
		end else begin
			s <= n;
		end
	end

	assign awready_out = s.awready;
	assign wready_out = s.wready;
	assign bresp_out = `RAC_RESP_OKAY;
	assign bvalid_out = s.bvalid;
	assign arready_out = s.arready;
	assign rdata_out = s.rdata;
	assign rresp_out = `RAC_RESP_OKAY;
	assign rvalid_out = s.rvalid;
	assign wr_en_out = s.wr_en;
	assign wr_addr_out = s.waddr;
	assign wr_data_out = s.wdata;
	assign wr_strb_out = s.wstrb;
	assign rd_addr_out = s.raddr;

	property p_read_fast;
		@(posedge clk_in) disable iff (!rst_n_in)
		arvalid_in && s.arready |-> ##2 s.rvalid;
	endproperty
	a_read_fast: assert property (p_read_fast) else $error("read answer late");
endmodule // rac_axil

/* rtl/rac_calendar.sv */
// BCD calendar date register with day advance
`include "rac_defs.svh"
module rac_calendar import rac_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic soft_rst_in,
	input wire logic day_tick_in,
	input wire logic wr_en_in,
	input wire logic unlock_in,
	input wire logic [31:0] wr_data_in,
	input wire logic [31:0] wr_mask_in,
	output logic [31:0] date_out,
	output logic [31:0] next_date_out
);
	rac_cal_s s;
	rac_cal_s n;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v == 8'h99) begin
			return 8'h00;
		end else if (v[3:0] == 4'h9) begin
			return {v[7:4] + 4'h1, 4'h0};
		end
		return v + 8'h01;
	endfunction

	always_comb begin
		logic [7:0] yr;
		logic [7:0] mo;
		logic [7:0] dy;
		logic [7:0] last;
		logic leap;
		logic [31:0] nd;
		logic [7:0] mi;
		logic [7:0] di;
		last = 8'h31;
		yr = s.date[31:24];
		mo = {3'h0, s.date[20:16]};
		dy = {2'h0, s.date[13:8]};
		mi = bcd_inc(mo);
		di = bcd_inc(dy);
		// Year mod 4 straight from the BCD digits, no binary convert
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mo)
			8'h02: last = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: last = 8'h30;
			default: last = 8'h31;
		endcase
		nd = s.date;
		nd[2:0] = (s.date[2:0] == 3'h6) ? 3'h0 : s.date[2:0] + 3'h1;
		if (dy == last) begin
			nd[13:8] = 6'h01;
			if (mo == 8'h12) begin
				nd[20:16] = 5'h01;
				nd[31:24] = bcd_inc(yr);
			end else begin
				nd[20:16] = mi[4:0];
			end
		end else begin
			nd[13:8] = di[5:0];
		end
		next_date_out = nd & `RAC_DATE_IMPL;
		n = s;
		if (day_tick_in) begin
			n.date = next_date_out;
		end
		if (wr_en_in && unlock_in) begin
			n.date = ((s.date & ~wr_mask_in) | (wr_data_in & wr_mask_in)) & `RAC_DATE_IMPL;
		end
		if (soft_rst_in) begin
			n.date = `RAC_DATE_RST;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s <= '{date: `RAC_DATE_RST};
		end else begin
			s <= n;
		end
	end

	assign date_out = s.date;

	property p_date_locked;
		@(posedge clk_in) disable iff (!rst_n_in)
		wr_en_in && !unlock_in && !day_tick_in && !soft_rst_in |=> $stable(s.date);
	endproperty
	a_date_locked: assert property (p_date_locked) else $error("locked date changed");

	property p_date_unimpl;
		@(posedge clk_in) disable iff (!rst_n_in)
		(s.date & ~`RAC_DATE_IMPL) == 32'h0;
	endproperty
	a_date_unimpl: assert property (p_date_unimpl) else $error("unused date bit set");
endmodule // rac_calendar

/* rtl/rac_defs.svh */
// Constants for the RTC alarm control block
// Behaviour
// - Alarm enable bit 15 gates alarm operation
// - Wrap option lets repeat counter roll to 0xff
// - Without wrap, repeat counter stops at zero
// - Disabled alarm: pulse value write sets pulse
// - Enabled alarm: pulse value read-only, shows pulse
// - Sync flag high within 32 ticks of rollover
// - Interval select picks half-second up to yearly
// - Yearly alarm on Feb 29 fires leap years
// - Hardware clears enable on last alarm event
// - Register read completes within 32 bus clocks
// - Alarm control cleared only by power-on reset
// - Date register holds BCD fields at fixed bits
// - Date writes need calendar write unlock bit
`ifndef RAC_DEFS_SVH
`define RAC_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define RAC_OFS_ALARM 8'h00
`define RAC_OFS_DATE 8'h04
`define RAC_OFS_CTRL 8'h08
`define RAC_OFS_TGT 8'h0c
`define RAC_OFS_STAT 8'h10
`define RAC_OFS_MASK 8'h14

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define RAC_BIT_ALM_EN 15
`define RAC_BIT_WRAP 14
`define RAC_BIT_PULSE 13
`define RAC_BIT_SYNC 12
`define RAC_BIT_RTC_ON 15
`define RAC_BIT_UNLOCK 3
`define RAC_DATE_IMPL 32'hff1f3f07
`define RAC_TGT_IMPL 32'h001f3f00
`define RAC_DATE_RST 32'h00010100
`define RAC_TGT_RST 32'h00010100
`define RAC_RPT_WRAP 8'hff
`define RAC_RESP_OKAY 2'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RAC_CORE_CLK_HZ 100000000
`define RAC_RTC_CLK_HZ 32768
`define RAC_RTC_TICK_CYCLES (`RAC_CORE_CLK_HZ / `RAC_RTC_CLK_HZ)
`define RAC_HALF_SEC_TICKS 16384
`define RAC_SYNC_GUARD 32
`define RAC_READ_LIMIT 32

`endif

/* rtl/rac_pkg.sv */
// Types shared by the RTC alarm control modules
package rac_pkg;
	typedef enum logic [3:0] {
		RAC_IV_HALF, RAC_IV_SEC, RAC_IV_10SEC, RAC_IV_MIN, RAC_IV_10MIN,
		RAC_IV_HOUR, RAC_IV_DAY, RAC_IV_WEEK, RAC_IV_MONTH, RAC_IV_YEAR
	} rac_interval_e;

	typedef struct packed {
		logic aw_held;
		logic w_held;
		logic awready;
		logic wready;
		logic bvalid;
		logic wr_en;
		logic [7:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic arready;
		logic rd_en;
		logic [7:0] raddr;
		logic rvalid;
		logic [31:0] rdata;
	} rac_axil_s;

	typedef struct packed {
		logic [31:0] date;
	} rac_cal_s;

	typedef struct packed {
		logic alarm_enable;
		logic wrap;
		logic pulse;
		logic [3:0] interval;
		logic [7:0] rpt;
		logic rtc_on;
		logic unlock;
		logic [31:0] tgt;
		logic irq_status;
		logic irq_mask;
		logic irq;
		logic alarm_evt;
		logic [15:0] div;
		logic [15:0] presc;
		logic half;
		logic [3:0] sec_u;
		logic [2:0] sec_t;
		logic [3:0] min_u;
		logic [2:0] min_t;
		logic [4:0] hour;
	} rac_main_s;
endpackage

/* rtl/rac_top.sv */
// RTC alarm control: time base, alarm engine and registers
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`include "rac_defs.svh"
module rac_top import rac_pkg::*; #(
	parameter logic [15:0] RTC_TICK_CYCLES = 16'(`RAC_RTC_TICK_CYCLES),
	parameter logic [15:0] HALF_SEC_TICKS = 16'(`RAC_HALF_SEC_TICKS)
) (
	input wire logic CORE_CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic OTHER_RESET_IN,
	input wire logic [7:0] S_AXI_AWADDR_IN,
	input wire logic S_AXI_AWVALID_IN,
	output logic S_AXI_AWREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic [3:0] S_AXI_WSTRB_IN,
	input wire logic S_AXI_WVALID_IN,
	output logic S_AXI_WREADY_OUT,
	output logic [1:0] S_AXI_BRESP_OUT,
	output logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	input wire logic [7:0] S_AXI_ARADDR_IN,
	input wire logic S_AXI_ARVALID_IN,
	output logic S_AXI_ARREADY_OUT,
	output logic [31:0] S_AXI_RDATA_OUT,
	output logic [1:0] S_AXI_RRESP_OUT,
	output logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	output logic ALARM_PULSE_OUT,
	output logic ALARM_EVENT_OUT,
	output logic IRQ_OUT
);
	localparam logic [15:0] SYNC_EDGE = HALF_SEC_TICKS - 16'(`RAC_SYNC_GUARD);
	localparam rac_main_s MAIN_RST = '{tgt: `RAC_TGT_RST, default: '0};

	rac_main_s s;
	rac_main_s n;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic [31:0] date;
	logic [31:0] next_date;
	logic day_tick;
	logic sync;
	logic [31:0] bm;
	logic [31:0] cur;
	logic [31:0] wd;

	// ----------------------------------------------------------------
	// Bus slave and calendar
	// ----------------------------------------------------------------
	rac_axil u_axil (
		.clk_in(CORE_CLK_IN),
		.rst_n_in(RESET_N_IN),
		.awaddr_in(S_AXI_AWADDR_IN),
		.awvalid_in(S_AXI_AWVALID_IN),
		.awready_out(S_AXI_AWREADY_OUT),
		.wdata_in(S_AXI_WDATA_IN),
		.wstrb_in(S_AXI_WSTRB_IN),
		.wvalid_in(S_AXI_WVALID_IN),
		.wready_out(S_AXI_WREADY_OUT),
		.bresp_out(S_AXI_BRESP_OUT),
		.bvalid_out(S_AXI_BVALID_OUT),
		.bready_in(S_AXI_BREADY_IN),
		.araddr_in(S_AXI_ARADDR_IN),
		.arvalid_in(S_AXI_ARVALID_IN),
		.arready_out(S_AXI_ARREADY_OUT),
		.rdata_out(S_AXI_RDATA_OUT),
		.rresp_out(S_AXI_RRESP_OUT),
		.rvalid_out(S_AXI_RVALID_OUT),
		.rready_in(S_AXI_RREADY_IN),
		.wr_en_out(wr_en),
		.wr_addr_out(wr_addr),
		.wr_data_out(wr_data),
		.wr_strb_out(wr_strb),
		.rd_addr_out(rd_addr),
		.rd_data_in(rd_data)
	);

	rac_calendar u_cal (
		.clk_in(CORE_CLK_IN),
		.rst_n_in(RESET_N_IN),
		.soft_rst_in(OTHER_RESET_IN),
		.day_tick_in(day_tick),
		.wr_en_in(wr_en && wr_addr == `RAC_OFS_DATE),
		.unlock_in(s.unlock),
		.wr_data_in(wr_data),
		.wr_mask_in(bm),
		.date_out(date),
		.next_date_out(next_date)
	);

	// ----------------------------------------------------------------
	// Register words
	// ----------------------------------------------------------------
	// Near a half-second edge the counter and enable may move mid-read
	assign sync = s.rtc_on && s.presc >= SYNC_EDGE;

	function automatic logic [31:0] reg_word(input logic [7:0] a, input rac_main_s st,
			input logic [31:0] dt, input logic sy);
		unique case (a)
			`RAC_OFS_ALARM: return {16'h0, st.alarm_enable, st.wrap, st.pulse, sy,
				st.interval, st.rpt};
			`RAC_OFS_DATE: return dt;
			`RAC_OFS_CTRL: return {16'h0, st.rtc_on, 11'h0, st.unlock, 3'h0};
			`RAC_OFS_TGT: return st.tgt;
			`RAC_OFS_STAT: return {31'h0, st.irq_status};
			`RAC_OFS_MASK: return {31'h0, st.irq_mask};
			default: return 32'h0;
		endcase
	endfunction

	assign rd_data = reg_word(rd_addr, s, date, sync);
	assign cur = reg_word(wr_addr, s, date, sync);
	assign bm = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
	assign wd = (cur & ~bm) | (wr_data & bm);

	// ----------------------------------------------------------------
	// Time base and alarm engine
	// ----------------------------------------------------------------
	always_comb begin
		logic rtc_tick;
		logic half_tick;
		logic sec_tick;
		logic ten_s;
		logic min_tick;
		logic ten_m;
		logic hour_tick;
		logic hit;
		rac_main_s keep;
		hit = 1'b0;
		keep = s;
		n = s;
		n.alarm_evt = 1'b0;
		rtc_tick = (s.div == RTC_TICK_CYCLES - 16'h1);
		n.div = rtc_tick ? 16'h0 : s.div + 16'h1;
		half_tick = 1'b0;
		if (rtc_tick && s.rtc_on) begin
			half_tick = (s.presc == HALF_SEC_TICKS - 16'h1);
			n.presc = half_tick ? 16'h0 : s.presc + 16'h1;
		end
		sec_tick = half_tick && s.half;
		ten_s = sec_tick && s.sec_u == 4'h9;
		min_tick = ten_s && s.sec_t == 3'h5;
		ten_m = min_tick && s.min_u == 4'h9;
		hour_tick = ten_m && s.min_t == 3'h5;
		day_tick = hour_tick && s.hour == 5'd23;
		if (half_tick) begin
			n.half = !s.half;
		end
		if (sec_tick) begin
			n.sec_u = ten_s ? 4'h0 : s.sec_u + 4'h1;
		end
		if (ten_s) begin
			n.sec_t = min_tick ? 3'h0 : s.sec_t + 3'h1;
		end
		if (min_tick) begin
			n.min_u = ten_m ? 4'h0 : s.min_u + 4'h1;
		end
		if (ten_m) begin
			n.min_t = hour_tick ? 3'h0 : s.min_t + 3'h1;
		end
		if (hour_tick) begin
			n.hour = day_tick ? 5'd0 : s.hour + 5'd1;
		end
		// Reserved codes never fire
		unique case (rac_interval_e'(s.interval))
			RAC_IV_HALF: hit = half_tick;
			RAC_IV_SEC: hit = sec_tick;
			RAC_IV_10SEC: hit = ten_s;
			RAC_IV_MIN: hit = min_tick;
			RAC_IV_10MIN: hit = ten_m;
			RAC_IV_HOUR: hit = hour_tick;
			RAC_IV_DAY: hit = day_tick;
			RAC_IV_WEEK: hit = day_tick && next_date[2:0] == 3'h0;
			RAC_IV_MONTH: hit = day_tick && next_date[13:8] == 6'h01;
			// A Feb 29 target only exists in leap years
			RAC_IV_YEAR: hit = day_tick
				&& (next_date & `RAC_TGT_IMPL) == s.tgt;
			default: hit = 1'b0;
		endcase
		if (hit && s.alarm_enable) begin
			n.alarm_evt = 1'b1;
			n.pulse = !s.pulse;
			if (s.rpt != 8'h00) begin
				n.rpt = s.rpt - 8'h01;
			end else if (s.wrap) begin
				n.rpt = `RAC_RPT_WRAP;
			end else begin
				n.alarm_enable = 1'b0;
			end
		end
		// Software write lands after the event in the same cycle
		if (wr_en) begin
			unique case (wr_addr)
				`RAC_OFS_ALARM: begin
					n.alarm_enable = wd[`RAC_BIT_ALM_EN];
					n.wrap = wd[`RAC_BIT_WRAP];
					if (!s.alarm_enable) begin
						n.pulse = wd[`RAC_BIT_PULSE];
					end
					n.interval = wd[11:8];
					n.rpt = wd[7:0];
				end
				`RAC_OFS_CTRL: begin
					n.rtc_on = wd[`RAC_BIT_RTC_ON];
					n.unlock = wd[`RAC_BIT_UNLOCK];
				end
				`RAC_OFS_TGT: n.tgt = wd & `RAC_TGT_IMPL;
				`RAC_OFS_MASK: n.irq_mask = wd[0];
				default: ;
			endcase
		end
		// Set beats a write-one clear in the same cycle
		n.irq_status = (s.irq_status && !(wr_en && wr_addr == `RAC_OFS_STAT
			&& wr_strb[0] && wr_data[0])) || n.alarm_evt;
		// Alarm control survives every reset but power-on
		if (OTHER_RESET_IN) begin
			keep = n;
			n = MAIN_RST;
			n.alarm_enable = keep.alarm_enable;
			n.wrap = keep.wrap;
			n.pulse = keep.pulse;
			n.interval = keep.interval;
			n.rpt = keep.rpt;
		end
		n.irq = n.irq_status && n.irq_mask;
	end

	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			s <= MAIN_RST;
		end else begin
			s <= n;
		end
	end

	assign ALARM_PULSE_OUT = s.pulse;
	assign ALARM_EVENT_OUT = s.alarm_evt;
	assign IRQ_OUT = s.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!RESET_N_IN);

	property p_evt_needs_en;
		s.alarm_evt |-> $past(s.alarm_enable);
	endproperty
	a_evt_needs_en: assert property (p_evt_needs_en) else $error("alarm while disabled");

	property p_wrap;
		s.alarm_enable && s.wrap && s.rpt == 8'h00 ##1 s.alarm_evt && !$past(wr_en)
			&& !$past(OTHER_RESET_IN) |-> s.rpt == 8'hff && s.alarm_enable;
	endproperty
	a_wrap: assert property (p_wrap) else $error("repeat count did not wrap");

	property p_stop_zero;
		!s.wrap && s.rpt == 8'h00 ##1 s.alarm_evt && !$past(wr_en) |-> s.rpt == 8'h00;
	endproperty
	a_stop_zero: assert property (p_stop_zero) else $error("repeat count left zero");

	property p_auto_off;
		!s.wrap && s.rpt == 8'h00 ##1 s.alarm_evt && !$past(wr_en) |-> !s.alarm_enable;
	endproperty
	a_auto_off: assert property (p_auto_off) else $error("enable not cleared");

	property p_pulse_write;
		wr_en && wr_addr == `RAC_OFS_ALARM && wr_strb[1] && !s.alarm_enable
			|=> s.pulse == $past(wr_data[`RAC_BIT_PULSE]);
	endproperty
	a_pulse_write: assert property (p_pulse_write) else $error("pulse value not loaded");

	property p_pulse_hold;
		$past(s.alarm_enable) && !s.alarm_evt |-> s.pulse == $past(s.pulse);
	endproperty
	a_pulse_hold: assert property (p_pulse_hold) else $error("pulse moved while enabled");

	property p_sync_rise;
		$rose(sync) && $past(s.rtc_on) |-> s.presc == SYNC_EDGE;
	endproperty
	a_sync_rise: assert property (p_sync_rise) else $error("sync flag rose off edge");

	property p_toggle;
		s.alarm_evt |-> s.pulse != $past(s.pulse);
	endproperty
	a_toggle: assert property (p_toggle) else $error("alarm did not toggle pulse");

	property p_reserved_quiet;
		s.interval > 4'h9 |=> !s.alarm_evt;
	endproperty
	a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved code fired");

	property p_por_only;
		OTHER_RESET_IN && !wr_en && !s.alarm_enable |=> s.rpt == $past(s.rpt);
	endproperty
	a_por_only: assert property (p_por_only) else $error("alarm lost on soft reset");
endmodule // rac_top

/* test/rtc_alarm_control_tb_top.sv */
// Self-checking testbench for the RTC alarm control block
`include "rac_defs.svh"
module rtc_alarm_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// Short time base: 2 core cycles per tick, 64 ticks per half second
	localparam int HALF_CYC = 128;
	logic clk, rst_n, oth_rst, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	wire logic aw_rdy, w_rdy, bvalid, ar_rdy, rvalid, pulse, evt, irq;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	int n_mismatch = 0;
	int n_tests = 0;

	rac_top #(.RTC_TICK_CYCLES(16'd2), .HALF_SEC_TICKS(16'd64)) dut (
		.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .OTHER_RESET_IN(oth_rst),
		.S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(aw_rdy),
		.S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
		.S_AXI_WREADY_OUT(w_rdy), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
		.S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
		.S_AXI_ARREADY_OUT(ar_rdy), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
		.S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .ALARM_PULSE_OUT(pulse),
		.ALARM_EVENT_OUT(evt), .IRQ_OUT(irq)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Reporting
	// ----------------------------------------------------------------
	task automatic final_report();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic hang(input string nm);
		n_mismatch++;
		$display("Error %s expected answer seen none", nm);
		final_report();
	endtask

	// ----------------------------------------------------------------
	// Bus cycles
	// ----------------------------------------------------------------
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		int i;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(posedge clk);
			if (awvalid && aw_rdy === 1'b1) awvalid <= 1'b0;
			if (wvalid && w_rdy === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				break;
			end
		end
		bready <= 1'b0;
		if (i == 200) hang("write response");
		chk("write response code", 32'(`RAC_RESP_OKAY), {30'h0, r});
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d);
		logic [1:0] r;
		int i;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(posedge clk);
			if (arvalid && ar_rdy === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				break;
			end
		end
		rready <= 1'b0;
		if (i == 200) hang("read response");
		chk("read response code", 32'(`RAC_RESP_OKAY), {30'h0, r});
	endtask

	// Counter and enable may move near a rollover: read until two agree
	task automatic rd_stab(output logic [31:0] d);
		logic [31:0] p;
		int i;
		axr(`RAC_OFS_ALARM, p);
		for (i = 0; i < 8; i++) begin
			axr(`RAC_OFS_ALARM, d);
			if ((d & 32'h0000cfff) === (p & 32'h0000cfff)) return;
			p = d;
		end
		hang("stable alarm read");
	endtask

	task automatic wait_evt(output int c, input int lim);
		for (c = 1; c <= lim; c++) begin
			@(posedge clk);
			if (evt === 1'b1) return;
		end
		hang("alarm event");
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic s_reset_map();
		logic [31:0] d;
		axr(`RAC_OFS_ALARM, d);
		chk("alarm after power-on", 32'h0, d);
		axw(8'h18, 32'hffffffff);
		axr(8'h18, d);
		chk("unmapped read", 32'h0, d);
	endtask

	task automatic s_pulse_init();
		logic [31:0] d;
		axw(`RAC_OFS_ALARM, 32'hffff2000);
		axr(`RAC_OFS_ALARM, d);
		chk("alarm upper bits and pulse", 32'h00002000, d);
		chk("pulse level", 32'h1, {31'h0, pulse});
	endtask

	task automatic s_date();
		logic [31:0] d;
		axw(`RAC_OFS_DATE, 32'h23121507);
		axr(`RAC_OFS_DATE, d);
		chk("locked date", `RAC_DATE_RST, d);
		axw(`RAC_OFS_CTRL, 32'h00000008);
		axw(`RAC_OFS_DATE, 32'h23121507);
		axr(`RAC_OFS_DATE, d);
		chk("unlocked date", 32'h23121507, d);
		axw(`RAC_OFS_CTRL, 32'h00008000);
	endtask

	// Last repeat clears enable without wrap, counter stays at zero
	task automatic s_count();
		logic [31:0] d;
		int c;
		axw(`RAC_OFS_ALARM, 32'h0000a001);
		wait_evt(c, 400);
		@(negedge clk);
		chk("pulse after first event", 32'h0, {31'h0, pulse});
		rd_stab(d);
		chk("count after first event", 32'h00008000, d & 32'h0000cfff);
		wait_evt(c, 400);
		rd_stab(d);
		chk("enable after last event", 32'h0, d & 32'h0000cfff);
		chk("pulse after last event", 32'h1, {31'h0, pulse});
		for (c = 0; c < 400; c++) begin
			@(posedge clk);
			if (evt === 1'b1) chk("event while disabled", 32'h0, 32'h1);
		end
	endtask

	task automatic s_wrap();
		logic [31:0] d;
		logic p;
		int c;
		axw(`RAC_OFS_ALARM, 32'h0000c000);
		wait_evt(c, 400);
		rd_stab(d);
		chk("wrapped count", 32'h0000c0ff, d & 32'h0000cfff);
		p = pulse;
		axw(`RAC_OFS_ALARM, {16'h0, 2'b11, ~p, 13'h00ff});
		axr(`RAC_OFS_ALARM, d);
		chk("pulse bit while enabled", {31'h0, p}, {31'h0, d[13]});
		chk("pulse level kept", {31'h0, p}, {31'h0, pulse});
	endtask

	task automatic s_irq();
		logic [31:0] d;
		axw(`RAC_OFS_ALARM, 32'h0);
		axr(`RAC_OFS_STAT, d);
		chk("sticky status", 32'h1, d);
		chk("masked irq", 32'h0, {31'h0, irq});
		axw(`RAC_OFS_MASK, 32'h1);
		repeat (2) @(posedge clk);
		chk("unmasked irq", 32'h1, {31'h0, irq});
		axw(`RAC_OFS_STAT, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq after clear", 32'h0, {31'h0, irq});
		axw(`RAC_OFS_MASK, 32'h0);
	endtask

	task automatic s_interval();
		int per [3] = '{HALF_CYC, 2 * HALF_CYC, 20 * HALF_CYC};
		int c;
		for (int k = 0; k < 3; k++) begin
			axw(`RAC_OFS_ALARM, 32'h0000c0ff | (k << 8));
			wait_evt(c, 3 * per[k]);
			wait_evt(c, 3 * per[k]);
			chk("alarm period", per[k], c);
		end
	endtask

	task automatic s_sync();
		logic [31:0] d;
		int c;
		axw(`RAC_OFS_ALARM, 32'h0000c0ff);
		wait_evt(c, 400);
		axr(`RAC_OFS_ALARM, d);
		chk("sync just after rollover", 32'h0, {31'h0, d[12]});
		repeat (HALF_CYC - 40) @(posedge clk);
		axr(`RAC_OFS_ALARM, d);
		chk("sync near rollover", 32'h1, {31'h0, d[12]});
	endtask

	task automatic s_resets();
		logic [31:0] d;
		int c;
		// Write just after a rollover, never while the sync flag is up
		wait_evt(c, 400);
		axw(`RAC_OFS_ALARM, 32'h00004305);
		@(posedge clk);
		oth_rst <= 1'b1;
		@(posedge clk);
		oth_rst <= 1'b0;
		axr(`RAC_OFS_ALARM, d);
		chk("alarm kept over other reset", 32'h00004305, d & 32'h0000cfff);
		axr(`RAC_OFS_CTRL, d);
		chk("control cleared by other reset", 32'h0, d);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		axr(`RAC_OFS_ALARM, d);
		chk("alarm after power-on", 32'h0, d);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		oth_rst = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		s_reset_map();
		s_pulse_init();
		s_date();
		s_count();
		s_wrap();
		s_irq();
		s_interval();
		s_sync();
		s_resets();
		final_report();
	end
endmodule // rtc_alarm_control_tb_top
